/* logic/aux_regulator_regs.sv */
// Auxiliary regulator control and on-state register bank with bus slave
//
// Overview of operation
// - Undervoltage action 00 does nothing and 01 switches off this regulator only.
// - Undervoltage action 10 requests a device reset, and 11 is reserved and acts as 00.
// - Every undervoltage event raises the interrupt pulse whatever action is set.
// - Hardware-control source 00 disables it, 01 follows input 1, 10 input 2, 11 either.
// - Under hardware control the voltage comes from the on code at 0, the sleep code at 1.
// - Hardware-control mode 00 and 10 give low power, 01 turns off, 11 uses the on mode.
// - A disabled regulator is discharged when the float bit is 0 and floats when it is 1.
// - Low-power variant bit 0 picks the 50mA variant and 1 picks the 20mA variant.
// - The chosen low-power variant applies whenever low power is in effect in any state.
// - Start-up slot 000 leaves the regulator off and 001 to 101 enable it in slots 1 to 5.
// - Start-up slot 110 and 111 hand the enable to hardware enable input 1 or 2.
// - On-state mode bit 0 is normal and 1 is low power, resetting to 0.
// - On voltage codes 00h to 0Eh give 0.90V plus 50mV a step, resetting to 0.
// - Voltage codes 0Fh to 1Fh give 1.70V plus 100mV a step, reaching 3.30V.
// - With a hardware enable, sleep slot 001 to 101 picks sleep entry in slot 5 down to slot 1.
`timescale 1ns/1ps
module aux_regulator_regs
  import aux_regulator_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // AXI4-Lite write address
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] AWADDR,
  // AXI4-Lite write data
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  // AXI4-Lite write response
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // AXI4-Lite read
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [31:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // System and sequencer
  input wire logic PWR_ON,
  input wire logic SEQ_STEP,
  input wire logic [2:0] SEQ_SLOT,
  input wire logic SEQ_SLEEP,
  input wire logic [2:0] SLEEP_SLOT,
  input wire logic [4:0] SLEEP_VCODE,
  input wire logic SLEEP_LOW_POWER,
  // Hardware control and enable inputs
  input wire logic HWC_IN1,
  input wire logic HWC_IN2,
  input wire logic HW_EN1,
  input wire logic HW_EN2,
  // Undervoltage monitor
  input wire logic UV_EVENT,
  // Regulator controls
  output logic REG_ENABLE,
  output logic [4:0] REG_VCODE,
  output logic [11:0] REG_MILLIVOLTS,
  output logic REG_LOW_POWER,
  output logic REG_LP_20MA,
  output logic REG_DISCHARGE,
  output logic REG_SWITCH_MODE,
  // Events
  output logic UV_IRQ,
  output logic SYS_RESET_REQ
);

  function automatic reg_sel_e decode(input logic [31:0] addr);
    reg_sel_e sel;
    sel = SEL_NONE;
    if (addr[31:18] == 14'h0000 && addr[1:0] == 2'h0) begin
      if (addr[17:2] == CTRL_IDX) sel = SEL_CTRL;
      else if (addr[17:2] == ON_IDX) sel = SEL_ON;
      else if (addr[17:2] == STAT_IDX) sel = SEL_STAT;
    end
    return sel;
  endfunction

  function automatic logic [11:0] code_to_mv(input logic [4:0] code);
    logic [11:0] mv;
    if (code <= CODE_LO_LAST) begin
      mv = BASE_LO_MV + 12'(STEP_LO_MV * 12'(code));
    end else begin
      mv = BASE_HI_MV
         + 12'(STEP_HI_MV * 12'(code - CODE_HI_FIRST));
    end
    return mv;
  endfunction

  // Bus state
  logic awready_q, awready_d, wready_q, wready_d;
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic do_write;
  reg_sel_e wsel, rsel;

  // Register contents
  logic [15:0] ctrl_q, ctrl_d, on_q, on_d;
  logic [15:0] stat_word;

  // Regulator state
  logic slot_on_q, slot_on_d, sleep_q, sleep_d, uv_off_q, uv_off_d;
  logic en_q, en_d, lp_q, lp_d, lp20_q, lp20_d;
  logic dis_q, dis_d, sw_q, sw_d, irq_q, irq_d, rst_q, rst_d;
  logic hwc_q, hwc_d;
  logic [4:0] vcode_q, vcode_d;
  logic [11:0] mv_q, mv_d;

  // Field views
  logic [1:0] uv_act, hwc_src, hwc_mode;
  logic [2:0] slot;
  logic [4:0] on_vcode;
  logic [2:0] sleep_entry;
  assign uv_act = ctrl_q[UV_ACT_LSB +: 2];
  assign hwc_src = ctrl_q[HWC_SRC_LSB +: 2];
  assign hwc_mode = ctrl_q[HWC_MODE_LSB +: 2];
  assign slot = on_q[SLOT_LSB +: 3];
  assign on_vcode = on_q[VCODE_LSB +: 5];
  assign sleep_entry = 3'(SLEEP_SLOT_SUM - SLEEP_SLOT);

  always_comb begin
    stat_word = 16'h0000;
    stat_word[ST_UV_OFF_BIT] = uv_off_q;
    stat_word[ST_EN_BIT] = en_q;
    stat_word[ST_HWC_BIT] = hwc_q;
    stat_word[ST_LP_BIT] = lp_q;
    stat_word[ST_SLEEP_BIT] = sleep_q;
    stat_word[ST_VCODE_LSB +: 5] = vcode_q;
  end

  // Write channel
  always_comb begin
    aw_full_d = aw_full_q;
    awaddr_d = awaddr_q;
    w_full_d = w_full_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    do_write = 1'b0;
    wsel = decode(awaddr_q);
    if (AWVALID && awready_q) begin
      aw_full_d = 1'b1;
      awaddr_d = AWADDR;
    end
    if (WVALID && wready_q) begin
      w_full_d = 1'b1;
      wdata_d = WDATA;
      wstrb_d = WSTRB;
    end
    if (BREADY && bvalid_q) begin
      bvalid_d = 1'b0;
    end
    if (aw_full_q && w_full_q && !bvalid_q) begin
      do_write = 1'b1;
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (wsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
    end
    awready_d = !aw_full_d;
    wready_d = !w_full_d;
  end

  // Read channel
  always_comb begin
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    rsel = decode(ARADDR);
    if (RREADY && rvalid_q) begin
      rvalid_d = 1'b0;
    end
    if (ARVALID && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      unique case (rsel)
        SEL_CTRL: rdata_d = {16'h0000, ctrl_q};
        SEL_ON: rdata_d = {16'h0000, on_q};
        SEL_STAT: rdata_d = {16'h0000, stat_word};
        SEL_NONE: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_DECERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  // Register file
  always_comb begin
    ctrl_d = ctrl_q;
    on_d = on_q;
    if (do_write) begin
      for (int b = 0; b < 2; b++) begin
        if (wstrb_q[b] && wsel == SEL_CTRL) begin
          ctrl_d[b*8 +: 8] = wdata_q[b*8 +: 8];
        end
        if (wstrb_q[b] && wsel == SEL_ON) begin
          on_d[b*8 +: 8] = wdata_q[b*8 +: 8];
        end
      end
    end
    ctrl_d = ctrl_d & CTRL_MASK;
    on_d = on_d & ON_MASK;
  end

  // Regulator behaviour
  always_comb begin
    logic hwc_act, base_en, sleep_code_ok, clr_uv;
    hwc_act = 1'b0;
    base_en = 1'b0;
    sleep_code_ok = 1'b0;
    clr_uv = 1'b0;
    unique case (hwc_src)
      2'h0: hwc_act = 1'b0;
      2'h1: hwc_act = HWC_IN1;
      2'h2: hwc_act = HWC_IN2;
      2'h3: hwc_act = HWC_IN1 | HWC_IN2;
    endcase
    // Start-up timeslot enable
    slot_on_d = slot_on_q;
    if (!PWR_ON || slot == SLOT_NONE || slot > SLOT_LAST) begin
      slot_on_d = 1'b0;
    end else if (SEQ_STEP && !SEQ_SLEEP && SEQ_SLOT == slot) begin
      slot_on_d = 1'b1;
    end
    // Sleep entry slot for hardware-enabled regulators
    sleep_code_ok = (SLEEP_SLOT != SLOT_NONE) && (SLEEP_SLOT <= SLOT_LAST);
    sleep_d = sleep_q;
    if (!SEQ_SLEEP || slot < SLOT_HWEN1 || !sleep_code_ok) begin
      sleep_d = 1'b0;
    end else if (SEQ_STEP && SEQ_SLOT == sleep_entry) begin
      sleep_d = 1'b1;
    end
    unique case (slot)
      SLOT_HWEN1: base_en = HW_EN1;
      SLOT_HWEN2: base_en = HW_EN2;
      default: base_en = slot_on_q;
    endcase
    // Undervoltage latch, set beats clear
    clr_uv = do_write && wsel == SEL_STAT && wstrb_q[0]
          && wdata_q[ST_UV_OFF_BIT];
    uv_off_d = uv_off_q && !clr_uv;
    if (UV_EVENT && uv_act == UV_REG_OFF) begin
      uv_off_d = 1'b1;
    end
    rst_d = UV_EVENT && uv_act == UV_SYS_RESET;
    irq_d = UV_EVENT;
    en_d = base_en && !uv_off_q
        && !(hwc_act && hwc_mode == HWM_OFF);
    if (hwc_act) begin
      lp_d = (hwc_mode == HWM_ON_MODE) ? on_q[ON_MODE_BIT] : 1'b1;
      vcode_d = ctrl_q[HWC_VPICK_BIT] ? SLEEP_VCODE : on_vcode;
    end else if (sleep_q) begin
      lp_d = SLEEP_LOW_POWER;
      vcode_d = SLEEP_VCODE;
    end else begin
      lp_d = on_q[ON_MODE_BIT];
      vcode_d = on_vcode;
    end
    hwc_d = hwc_act;
    lp20_d = lp_d && ctrl_q[LPV_BIT];
    dis_d = !en_d && !ctrl_q[FLOAT_BIT];
    sw_d = ctrl_q[SWITCH_BIT];
    mv_d = code_to_mv(vcode_d);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
      ctrl_q <= CTRL_RESET;
      on_q <= ON_RESET;
      slot_on_q <= 1'b0;
      sleep_q <= 1'b0;
      uv_off_q <= 1'b0;
      en_q <= 1'b0;
      lp_q <= 1'b0;
      lp20_q <= 1'b0;
      dis_q <= 1'b0;
      sw_q <= 1'b0;
      irq_q <= 1'b0;
      rst_q <= 1'b0;
      hwc_q <= 1'b0;
      vcode_q <= 5'h00;
      mv_q <= BASE_LO_MV;
    end else begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      ctrl_q <= ctrl_d;
      on_q <= on_d;
      slot_on_q <= slot_on_d;
      sleep_q <= sleep_d;
      uv_off_q <= uv_off_d;
      en_q <= en_d;
      lp_q <= lp_d;
      lp20_q <= lp20_d;
      dis_q <= dis_d;
      sw_q <= sw_d;
      irq_q <= irq_d;
      rst_q <= rst_d;
      hwc_q <= hwc_d;
      vcode_q <= vcode_d;
      mv_q <= mv_d;
    end
  end

  assign AWREADY = awready_q;
  assign WREADY = wready_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign ARREADY = arready_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;
  assign REG_ENABLE = en_q;
  assign REG_VCODE = vcode_q;
  assign REG_MILLIVOLTS = mv_q;
  assign REG_LOW_POWER = lp_q;
  assign REG_LP_20MA = lp20_q;
  assign REG_DISCHARGE = dis_q;
  assign REG_SWITCH_MODE = sw_q;
  assign UV_IRQ = irq_q;
  assign SYS_RESET_REQ = rst_q;

endmodule

/* shared/aux_regulator_pkg.sv */
// Register map, field layout and codes of the auxiliary regulator bank
package aux_regulator_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] CTRL_IDX = 16'h4074;
  localparam logic [15:0] ON_IDX = 16'h4075;
  localparam logic [15:0] STAT_IDX = 16'h4078;

  // Control register fields
  localparam int UV_ACT_LSB = 14;
  localparam int HWC_SRC_LSB = 11;
  localparam int HWC_VPICK_BIT = 10;
  localparam int HWC_MODE_LSB = 8;
  localparam int FLOAT_BIT = 7;
  localparam int SWITCH_BIT = 6;
  localparam int LPV_BIT = 0;
  localparam logic [15:0] CTRL_MASK = 16'hdfc1;
  localparam logic [15:0] CTRL_RESET = 16'h0200;

  // On-state register fields
  localparam int SLOT_LSB = 13;
  localparam int ON_MODE_BIT = 8;
  localparam int VCODE_LSB = 0;
  localparam logic [15:0] ON_MASK = 16'he11f;
  localparam logic [15:0] ON_RESET = 16'h0000;

  // Status register fields
  localparam int ST_UV_OFF_BIT = 0;
  localparam int ST_EN_BIT = 1;
  localparam int ST_HWC_BIT = 2;
  localparam int ST_LP_BIT = 3;
  localparam int ST_SLEEP_BIT = 4;
  localparam int ST_VCODE_LSB = 8;

  // Undervoltage actions
  localparam logic [1:0] UV_IGNORE = 2'h0;
  localparam logic [1:0] UV_REG_OFF = 2'h1;
  localparam logic [1:0] UV_SYS_RESET = 2'h2;

  // Hardware-control mode codes
  localparam logic [1:0] HWM_OFF = 2'h1;
  localparam logic [1:0] HWM_ON_MODE = 2'h3;

  // Slot codes
  localparam logic [2:0] SLOT_NONE = 3'h0;
  localparam logic [2:0] SLOT_LAST = 3'h5;
  localparam logic [2:0] SLOT_HWEN1 = 3'h6;
  localparam logic [2:0] SLOT_HWEN2 = 3'h7;
  localparam logic [2:0] SLEEP_SLOT_SUM = 3'h6;

  // Voltage code translation
  localparam logic [4:0] CODE_LO_LAST = 5'h0e;
  localparam logic [4:0] CODE_HI_FIRST = 5'h0f;
  localparam logic [11:0] BASE_LO_MV = 12'd900;
  localparam logic [11:0] STEP_LO_MV = 12'd50;
  localparam logic [11:0] BASE_HI_MV = 12'd1700;
  localparam logic [11:0] STEP_HI_MV = 12'd100;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum {SEL_NONE, SEL_CTRL, SEL_ON, SEL_STAT} reg_sel_e;

endpackage

/* tb/aux_regulator_checker.sv */
// Port-level assertions for the auxiliary regulator register bank
`timescale 1ns/1ps
module aux_regulator_checker
  import aux_regulator_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Register bus
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [1:0] BRESP,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [31:0] RDATA,
  // Regulator and events
  input wire logic UV_EVENT,
  input wire logic UV_IRQ,
  input wire logic SYS_RESET_REQ,
  input wire logic REG_ENABLE,
  input wire logic [4:0] REG_VCODE,
  input wire logic [11:0] REG_MILLIVOLTS,
  input wire logic REG_LOW_POWER,
  input wire logic REG_LP_20MA,
  input wire logic REG_DISCHARGE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence write_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence read_taken;
    ARVALID && ARREADY;
  endsequence
  chk_write_answer: assert property (write_taken |-> ##2 BVALID)
    else $error("write response not after two edges");
  chk_read_answer: assert property (read_taken |=> RVALID)
    else $error("read data not after one edge");
  chk_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  chk_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped early");
  chk_ar_blocked: assert property (RVALID |-> !ARREADY)
    else $error("read address taken while data pending");
  chk_irq_follow: assert property (UV_IRQ == $past(UV_EVENT))
    else $error("interrupt does not follow undervoltage");
  chk_sysreset_cause: assert property (SYS_RESET_REQ |-> UV_IRQ && $past(UV_EVENT))
    else $error("device reset without undervoltage");
  chk_discharge_off: assert property (REG_DISCHARGE |-> !REG_ENABLE)
    else $error("discharge while enabled");
  chk_lp_variant: assert property (REG_LP_20MA |-> REG_LOW_POWER)
    else $error("low power variant outside low power");
  chk_mv_low: assert property (REG_VCODE <= 5'h0e |->
    REG_MILLIVOLTS == 12'(900 + 50 * REG_VCODE)) else $error("low range mV");
  chk_mv_high: assert property (REG_VCODE >= 5'h0f |->
    REG_MILLIVOLTS == 12'(1700 + 100 * (REG_VCODE - 15)))
    else $error("high range mV");
endmodule
bind aux_regulator_regs aux_regulator_checker u_chk (.*);

/* tb/regulator_five_control_regs_bench.sv */
// Self-checking bench for the auxiliary regulator register bank
`timescale 1ns/1ps
module regulator_five_control_regs_bench;
  import aux_regulator_pkg::*;
  logic CLK = 0, RESET = 1, AWVALID = 0, WVALID = 0, BREADY = 0;
  logic ARVALID = 0, RREADY = 0, AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [31:0] AWADDR = 0, WDATA = 0, ARADDR = 0, RDATA;
  logic [3:0] WSTRB = 4'h3;
  logic [1:0] BRESP, RRESP;
  logic PWR_ON = 0, SEQ_STEP = 0, SEQ_SLEEP = 0, SLEEP_LOW_POWER = 0;
  logic [2:0] SEQ_SLOT = 0, SLEEP_SLOT = 0;
  logic [4:0] SLEEP_VCODE = 5'h1a, REG_VCODE;
  logic HWC_IN1 = 0, HWC_IN2 = 0, HW_EN1 = 0, HW_EN2 = 0, UV_EVENT = 0;
  logic REG_ENABLE, REG_LOW_POWER, REG_LP_20MA, REG_DISCHARGE;
  logic REG_SWITCH_MODE, UV_IRQ, SYS_RESET_REQ;
  logic [11:0] REG_MILLIVOLTS;
  logic [4:0] codes [6] = '{5'h00, 5'h01, 5'h0e, 5'h0f, 5'h1e, 5'h1f};
  int n_errors = 0, comparisons = 0;
  localparam logic [31:0] A_CTRL = {14'h0, CTRL_IDX, 2'h0};
  localparam logic [31:0] A_ON = {14'h0, ON_IDX, 2'h0};
  localparam logic [31:0] A_STAT = {14'h0, STAT_IDX, 2'h0};
  localparam logic [31:0] A_BAD = 32'h00000020;

  aux_regulator_regs u_dut (.*);
  always #20 CLK = ~CLK;

  task automatic final_report;
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, s);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d,
                    input logic [1:0] r);
    int i;
    AWADDR <= a;
    WDATA <= {16'h0, d};
    AWVALID <= 1;
    WVALID <= 1;
    for (i = 0; i < 40; i++) begin
      @(posedge CLK);
      if (AWVALID && AWREADY) AWVALID <= 0;
      if (WVALID && WREADY) WVALID <= 0;
      if (BVALID && BREADY) break;
      if (BVALID) BREADY <= 1;
    end
    if (i == 40) cmp("write wait", 1, 0);
    if (i == 40) final_report();
    BREADY <= 0;
    cmp("BRESP", r, BRESP);
  endtask
  task automatic rd(input logic [31:0] a, e, input logic [1:0] r);
    int i;
    ARADDR <= a;
    ARVALID <= 1;
    for (i = 0; i < 40; i++) begin
      @(posedge CLK);
      if (ARVALID && ARREADY) ARVALID <= 0;
      if (RVALID && RREADY) break;
      if (RVALID) RREADY <= 1;
    end
    if (i == 40) cmp("read wait", 1, 0);
    if (i == 40) final_report();
    RREADY <= 0;
    cmp("RDATA", e, RDATA);
    cmp("RRESP", r, RRESP);
  endtask
  function automatic logic [31:0] mv(input logic [4:0] c);
    return (c <= 5'h0e) ? 900 + 50 * c : 1700 + 100 * (c - 15);
  endfunction
  task automatic outs(input logic en, lp, l20, input logic [4:0] vc);
    wt(3);
    cmp("REG_ENABLE", en, REG_ENABLE);
    cmp("REG_LOW_POWER", lp, REG_LOW_POWER);
    cmp("REG_LP_20MA", l20, REG_LP_20MA);
    cmp("REG_VCODE", vc, REG_VCODE);
    cmp("REG_MILLIVOLTS", mv(vc), REG_MILLIVOLTS);
  endtask
  task automatic hardware_control(input logic [15:0] c, input logic en, lp, l20,
                     input logic [4:0] vc);
    wr(A_CTRL, c, RESP_OKAY);
    outs(en, lp, l20, vc);
  endtask
  task automatic step(input logic [2:0] s, input logic en);
    SEQ_SLOT <= s;
    SEQ_STEP <= 1;
    @(posedge CLK);
    SEQ_STEP <= 0;
    wt(3);
    cmp("REG_ENABLE", en, REG_ENABLE);
  endtask
  task automatic uv(input logic [1:0] act);
    wr(A_CTRL, {act, 14'h0}, RESP_OKAY);
    wt(2);
    UV_EVENT <= 1;
    @(posedge CLK);
    UV_EVENT <= 0;
    @(negedge CLK);
    cmp("SYS_RESET_REQ", act == 2'h2, SYS_RESET_REQ);
    cmp("UV_IRQ", 1, UV_IRQ);
    wt(2);
    cmp("REG_ENABLE", act != 2'h1, REG_ENABLE);
    rd(A_STAT, {30'h0, act != 2'h1, act == 2'h1}, RESP_OKAY);
    wr(A_STAT, 16'h0001, RESP_OKAY);
  endtask

  initial begin
    wt(6);
    RESET <= 0;
    rd(A_CTRL, 32'h00000200, RESP_OKAY);
    rd(A_ON, 32'h00000000, RESP_OKAY);
    outs(0, 0, 0, 5'h00);
    cmp("REG_DISCHARGE", 1, REG_DISCHARGE);
    cmp("REG_SWITCH_MODE", 0, REG_SWITCH_MODE);
    wr(A_CTRL, 16'hffff, RESP_OKAY);
    rd(A_CTRL, {16'h0, CTRL_MASK}, RESP_OKAY);
    wt(3);
    cmp("REG_SWITCH_MODE", 1, REG_SWITCH_MODE);
    cmp("REG_DISCHARGE", 0, REG_DISCHARGE);
    WSTRB <= 4'h1;
    wr(A_CTRL, 16'h0000, RESP_OKAY);
    WSTRB <= 4'h3;
    rd(A_CTRL, 32'h0000df00, RESP_OKAY);
    wr(A_BAD, 16'h0001, RESP_DECERR);
    rd(A_BAD, 32'h0, RESP_DECERR);
    wr(A_CTRL, 16'h0200, RESP_OKAY);
    HW_EN1 <= 1;
    foreach (codes[k]) begin
      wr(A_ON, 16'hc000 | codes[k], RESP_OKAY);
      outs(1, 0, 0, codes[k]);
    end
    wr(A_ON, 16'he000, RESP_OKAY);
    outs(0, 0, 0, 5'h00);
    HW_EN2 <= 1;
    outs(1, 0, 0, 5'h00);
    wr(A_ON, 16'h6000, RESP_OKAY);
    PWR_ON <= 1;
    step(3'h2, 0);
    step(3'h3, 1);
    wr(A_ON, 16'h6100, RESP_OKAY);
    outs(1, 1, 0, 5'h00);
    PWR_ON <= 0;
    wr(A_ON, 16'hc000, RESP_OKAY);
    SLEEP_SLOT <= 3'h1;
    SEQ_SLEEP <= 1;
    SLEEP_LOW_POWER <= 1;
    step(3'h4, 1);
    outs(1, 0, 0, 5'h00);
    step(3'h5, 1);
    outs(1, 1, 0, 5'h1a);
    SEQ_SLEEP <= 0;
    HWC_IN1 <= 1;
    hardware_control(16'h0001, 1, 0, 0, 5'h00);
    hardware_control(16'h0801, 1, 1, 1, 5'h00);
    hardware_control(16'h1001, 1, 0, 0, 5'h00);
    HWC_IN1 <= 0;
    HWC_IN2 <= 1;
    hardware_control(16'h1001, 1, 1, 1, 5'h00);
    hardware_control(16'h0801, 1, 0, 0, 5'h00);
    HWC_IN1 <= 1;
    HWC_IN2 <= 0;
    hardware_control(16'h1801, 1, 1, 1, 5'h00);
    hardware_control(16'h0b00, 1, 0, 0, 5'h00);
    hardware_control(16'h0e00, 1, 1, 0, 5'h1a);
    wr(A_CTRL, 16'h0900, RESP_OKAY);
    wt(3);
    cmp("REG_ENABLE", 0, REG_ENABLE);
    HWC_IN1 <= 0;
    for (int a = 0; a < 4; a++) uv(a[1:0]);
    final_report();
  end
endmodule
